/* pkg/nvm_pkg.sv */
// constants and types shared by the nvm data access block
package nvm_pkg;
   // indirect route to the control register
   localparam logic [7:0] CTRL_PTR = 8'h40;
   localparam logic [7:0] CTRL_BANK = 8'h01;
   // control register field positions
   localparam int FETCH_TRIG_BIT = 0;
   localparam int FETCH_PERMIT_BIT = 1;
   localparam int STORE_TRIG_BIT = 2;
   localparam int STORE_PERMIT_BIT = 3;
   // reset values
   localparam logic [7:0] PTR_RST = 8'h00;
   localparam logic [7:0] BANK_RST = 8'h00;
   localparam logic [7:0] RDATA_RST = 8'h00;
   // defaults: capacity, read length, write timer ticks
   localparam int ADDR_W_DEF = 8;
   localparam int READ_CYCLES_DEF = 4;
   localparam int WRITE_TICKS_DEF = 2;

   typedef enum logic [2:0] {
      SEL_ADDR = 3'h0,
      SEL_DATA = 3'h1,
      SEL_PTR = 3'h2,
      SEL_BANK = 3'h3,
      SEL_IND = 3'h4
   } sfr_sel_e;

   typedef struct packed {
      logic wr;
      logic rd;
      sfr_sel_e sel;
      logic [7:0] wdata;
   } sfr_req_s;

   typedef enum logic [2:0] {
      ST_IDLE = 3'h1,
      ST_FETCH = 3'h2,
      ST_STORE = 3'h4
   } cycle_e;
endpackage

/* rtl/eeprom_data_access.sv */
// byte-wide access controller for the nonvolatile data array
// Operation
// R1 - array of 64, 128 or 256 bytes
// R2 - byte access only through three registers
// R3 - control reached via pointer 40H, bank 01H
// R4 - address width tracks capacity, upper bits zero
// R5 - store permit required before any write
// R6 - store trigger starts write, clears when done
// R7 - store trigger ignored without earlier permit
// R8 - fetch permit required before any read
// R9 - fetch trigger starts read, clears when done
// R10 - fetch trigger ignored without earlier permit
// R11 - permit must precede trigger by a write
// R12 - never both triggers at once
// R13 - store trigger reads one while write busy
// R14 - read result held in data register
// R15 - write timed by asynchronous timer, synchronised
// R16 - write end sets done and shared flags
// R17 - power-on clears store permit and bank
// R18 - data register is eight-bit read/write
// R19 - read completes in fixed cycle count
`timescale 1ns/1ns
module eeprom_data_access #(
   parameter int ADDR_W = nvm_pkg::ADDR_W_DEF,
   parameter int READ_CYCLES = nvm_pkg::READ_CYCLES_DEF,
   parameter int WRITE_TICKS = nvm_pkg::WRITE_TICKS_DEF
) (
   input wire logic clk_in,
   input wire logic rstn_in,
   input wire nvm_pkg::sfr_req_s sfr_in,
   input wire logic timer_tick_in,
   input wire logic write_done_flag_clr_in,
   input wire logic mf_service_in,
   output logic [7:0] rdata_out,
   output logic write_done_flag_out,
   output logic mf_request_out
);
   import nvm_pkg::*;

   localparam int DEPTH = 1 << ADDR_W;

   function automatic logic ctrl_hit(input logic [7:0] ptr,
                                     input logic [7:0] bank);
      ctrl_hit = (ptr == CTRL_PTR) && (bank == CTRL_BANK);
   endfunction

   logic rst_meta_r;
   logic rst_sync_r;
   logic rstn;

   always_ff @(posedge clk_in or negedge rstn_in) begin
      if (!rstn_in) begin
         rst_meta_r <= 1'b0;
         rst_sync_r <= 1'b0;
      end else begin
         rst_meta_r <= 1'b1;
         rst_sync_r <= rst_meta_r;
      end
   end
   assign rstn = rst_sync_r;

   // timer tick: three stages, a change counts once stages two and three agree
   logic tick_s1_r;
   logic tick_s2_r;
   logic tick_s3_r;
   logic tick_lvl_r;
   logic tick_lvl_nxt;
   logic tick_edge;
   always_comb begin
      tick_lvl_nxt = tick_lvl_r;
      if (tick_s2_r == tick_s3_r) begin
         tick_lvl_nxt = tick_s3_r;
      end
   end
   assign tick_edge = tick_lvl_nxt && !tick_lvl_r;
   always_ff @(posedge clk_in or negedge rstn) begin
      if (!rstn) begin
         tick_s1_r <= 1'b0;
         tick_s2_r <= 1'b0;
         tick_s3_r <= 1'b0;
         tick_lvl_r <= 1'b0;
      end else begin
         tick_s1_r <= timer_tick_in;
         tick_s2_r <= tick_s1_r;
         tick_s3_r <= tick_s2_r;
         tick_lvl_r <= tick_lvl_nxt;
      end
   end

   logic [7:0] mem_r [DEPTH];
   logic mem_we;
   cycle_e state_r, state_nxt;
   logic [ADDR_W-1:0] addr_r, addr_nxt;
   logic [7:0] data_r, data_nxt;
   logic [7:0] ptr_r, ptr_nxt;
   logic [7:0] bank_r, bank_nxt;
   logic store_permit_r, store_permit_nxt;
   logic store_trig_r, store_trig_nxt;
   logic fetch_permit_r, fetch_permit_nxt;
   logic fetch_trig_r, fetch_trig_nxt;
   logic [7:0] cnt_r, cnt_nxt;
   logic [7:0] rdata_r, rdata_nxt;
   logic done_flag_r, done_flag_nxt;
   logic mf_req_r, mf_req_nxt;
   logic wr_ctrl;
   logic done_set;
   logic [7:0] ctrl_view;
   assign wr_ctrl = sfr_in.wr && (sfr_in.sel == SEL_IND)
                    && ctrl_hit(ptr_r, bank_r); // [R3]
   assign ctrl_view = {4'h0, store_permit_r, store_trig_r,
                       fetch_permit_r, fetch_trig_r}; // [R13]

   always_comb begin
      state_nxt = state_r;
      addr_nxt = addr_r;
      data_nxt = data_r;
      ptr_nxt = ptr_r;
      bank_nxt = bank_r;
      store_permit_nxt = store_permit_r;
      store_trig_nxt = store_trig_r;
      fetch_permit_nxt = fetch_permit_r;
      fetch_trig_nxt = fetch_trig_r;
      cnt_nxt = cnt_r;
      rdata_nxt = rdata_r;
      mem_we = 1'b0;
      done_set = 1'b0;
      if (sfr_in.wr) begin
         case (sfr_in.sel)
            SEL_ADDR: addr_nxt = sfr_in.wdata[ADDR_W-1:0]; // [R4]
            SEL_DATA: data_nxt = sfr_in.wdata; // [R18]
            SEL_PTR: ptr_nxt = sfr_in.wdata;
            SEL_BANK: bank_nxt = sfr_in.wdata;
            default: ;
         endcase
      end
      if (wr_ctrl) begin
         store_permit_nxt = sfr_in.wdata[STORE_PERMIT_BIT];
         fetch_permit_nxt = sfr_in.wdata[FETCH_PERMIT_BIT];
      end
      case (state_r)
         ST_IDLE: begin
            // permit must come from an earlier write [R11]
            if (wr_ctrl && store_permit_r && sfr_in.wdata[STORE_TRIG_BIT]
                && !sfr_in.wdata[FETCH_TRIG_BIT]) begin // [R5] [R7] [R12]
               state_nxt = ST_STORE;
               store_trig_nxt = 1'b1; // [R6]
               cnt_nxt = 8'h00;
            end else if (wr_ctrl && sfr_in.wdata[FETCH_TRIG_BIT]
                         && fetch_permit_r
                         && !sfr_in.wdata[STORE_TRIG_BIT]) begin // [R8] [R10]
               state_nxt = ST_FETCH;
               fetch_trig_nxt = 1'b1; // [R9]
               cnt_nxt = 8'h00;
            end
         end
         ST_FETCH: begin
            cnt_nxt = cnt_r + 8'h01;
            if (cnt_r == 8'(READ_CYCLES - 1)) begin // [R19]
               data_nxt = mem_r[addr_r]; // [R14]
               fetch_trig_nxt = 1'b0; // [R9]
               state_nxt = ST_IDLE;
            end
         end
         ST_STORE: begin
            if (tick_edge) begin // [R15]
               cnt_nxt = cnt_r + 8'h01;
               if (cnt_r == 8'(WRITE_TICKS - 1)) begin
                  mem_we = 1'b1;
                  store_trig_nxt = 1'b0; // [R6]
                  done_set = 1'b1;
                  state_nxt = ST_IDLE;
               end
            end
         end
         default: begin
            state_nxt = ST_IDLE;
            store_trig_nxt = 1'b0;
            fetch_trig_nxt = 1'b0;
         end
      endcase
      // a set in the same cycle as a clear wins
      done_flag_nxt = done_set || (done_flag_r && !write_done_flag_clr_in);
      mf_req_nxt = done_set || (mf_req_r && !mf_service_in); // [R16]
      if (sfr_in.rd) begin
         case (sfr_in.sel)
            SEL_ADDR: rdata_nxt = 8'(addr_r); // [R4]
            SEL_DATA: rdata_nxt = data_r;
            SEL_PTR: rdata_nxt = ptr_r;
            SEL_BANK: rdata_nxt = bank_r;
            SEL_IND: rdata_nxt = ctrl_hit(ptr_r, bank_r) ? ctrl_view
                                                           : 8'h00; // [R2]
            default: rdata_nxt = 8'h00;
         endcase
      end
   end

   always_ff @(posedge clk_in or negedge rstn) begin
      if (!rstn) begin
         state_r <= ST_IDLE;
         addr_r <= '0;
         data_r <= 8'h00;
         ptr_r <= PTR_RST;
         bank_r <= BANK_RST; // [R17]
         store_permit_r <= 1'b0; // [R17]
         store_trig_r <= 1'b0;
         fetch_permit_r <= 1'b0;
         fetch_trig_r <= 1'b0;
         cnt_r <= 8'h00;
         rdata_r <= RDATA_RST;
         done_flag_r <= 1'b0;
         mf_req_r <= 1'b0;
      end else begin
         state_r <= state_nxt;
         addr_r <= addr_nxt;
         data_r <= data_nxt;
         ptr_r <= ptr_nxt;
         bank_r <= bank_nxt;
         store_permit_r <= store_permit_nxt;
         store_trig_r <= store_trig_nxt;
         fetch_permit_r <= fetch_permit_nxt;
         fetch_trig_r <= fetch_trig_nxt;
         cnt_r <= cnt_nxt;
         rdata_r <= rdata_nxt;
         done_flag_r <= done_flag_nxt;
         mf_req_r <= mf_req_nxt;
      end
   end

   // nonvolatile contents: no reset
   always_ff @(posedge clk_in) begin
      if (mem_we) begin
         mem_r[addr_r] <= data_r; // [R1]
      end
   end

   assign rdata_out = rdata_r;
   assign write_done_flag_out = done_flag_r;
   assign mf_request_out = mf_req_r;

   property p_store_refused;
      @(posedge clk_in) disable iff (!rstn)
      (state_r == ST_IDLE) && wr_ctrl && !store_permit_r
      |=> !store_trig_r;
   endproperty
   a_store_refused: assert property (p_store_refused) // [R7]
      else $error("store started without permit");
   property p_fetch_refused;
      @(posedge clk_in) disable iff (!rstn)
      (state_r == ST_IDLE) && wr_ctrl && !fetch_permit_r
      |=> !fetch_trig_r;
   endproperty
   a_fetch_refused: assert property (p_fetch_refused) // [R10]
      else $error("fetch started without permit");
   property p_store_start;
      @(posedge clk_in) disable iff (!rstn)
      (state_r == ST_IDLE) && wr_ctrl && store_permit_r
      && sfr_in.wdata[STORE_TRIG_BIT] && !sfr_in.wdata[FETCH_TRIG_BIT]
      |=> store_trig_r && (state_r == ST_STORE);
   endproperty
   a_store_start: assert property (p_store_start) // [R6]
      else $error("permitted store did not start");
   property p_fetch_len;
      @(posedge clk_in) disable iff (!rstn)
      $rose(fetch_trig_r) |-> fetch_trig_r[*4] ##1 !fetch_trig_r;
   endproperty
   a_fetch_len: assert property (p_fetch_len) // [R19]
      else $error("fetch length wrong");
   property p_fetch_data;
      @(posedge clk_in) disable iff (!rstn)
      $fell(fetch_trig_r) && $stable(addr_r) |-> data_r == mem_r[addr_r];
   endproperty
   a_fetch_data: assert property (p_fetch_data) // [R14]
      else $error("fetched byte not in data register");
   property p_done_flags;
      @(posedge clk_in) disable iff (!rstn)
      $fell(store_trig_r) |-> write_done_flag_out && mf_request_out;
   endproperty
   a_done_flags: assert property (p_done_flags) // [R16]
      else $error("write end flags not set");
   property p_store_hold;
      @(posedge clk_in) disable iff (!rstn)
      store_trig_r && !tick_edge |=> store_trig_r;
   endproperty
   a_store_hold: assert property (p_store_hold) // [R15]
      else $error("write ended without timer tick");
   property p_addr_read;
      @(posedge clk_in) disable iff (!rstn)
      sfr_in.rd && (sfr_in.sel == SEL_ADDR) |=> rdata_out == 8'($past(addr_r));
   endproperty
   a_addr_read: assert property (p_addr_read) // [R4]
      else $error("address readback wrong");
   property p_one_cycle;
      @(posedge clk_in) disable iff (!rstn)
      !(store_trig_r && fetch_trig_r);
   endproperty
   a_one_cycle: assert property (p_one_cycle) // [R12]
      else $error("read and write cycles together");
endmodule

/* testbench/eeprom_data_access_bench.sv */
// self-checking bench for the nvm data access block
`timescale 1ns/1ns
module eeprom_data_access_bench;
   import nvm_pkg::*;
   logic clk_in = 1'b0;
   logic rstn_in = 1'b0;
   sfr_req_s sfr_in = '0;
   logic timer_tick_in = 1'b0;
   logic write_done_flag_clr_in = 1'b0;
   logic mf_service_in = 1'b0;
   logic [7:0] rdata_out;
   logic write_done_flag_out;
   logic mf_request_out;
   int error_cnt = 0;
   int samples_checked = 0;
   logic [7:0] got;

   always #5 clk_in = ~clk_in;

   // smallest variant: six address bits
   eeprom_data_access #(.ADDR_W(6), .READ_CYCLES(4), .WRITE_TICKS(2)) dut (
      .clk_in(clk_in),
      .rstn_in(rstn_in),
      .sfr_in(sfr_in),
      .timer_tick_in(timer_tick_in),
      .write_done_flag_clr_in(write_done_flag_clr_in),
      .mf_service_in(mf_service_in),
      .rdata_out(rdata_out),
      .write_done_flag_out(write_done_flag_out),
      .mf_request_out(mf_request_out)
   );

   task complete_run;
      if (error_cnt == 0 && samples_checked > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask

   task chk(input logic [7:0] act, input logic [7:0] exp, input string what);
      samples_checked++;
      if (act !== exp) begin
         error_cnt++;
         $display("MISMATCH t=%0t %s got %h exp %h", $time, what, act, exp);
      end
   endtask

   // all register tasks start and end at a falling edge
   task wr_reg(input sfr_sel_e sel, input logic [7:0] d);
      sfr_in.wr = 1'b1;
      sfr_in.sel = sel;
      sfr_in.wdata = d;
      @(negedge clk_in);
      sfr_in = '0;
      // one idle cycle so the next call never re-raises a strobe at once
      @(negedge clk_in);
   endtask

   task rd_reg(input sfr_sel_e sel);
      sfr_in.rd = 1'b1;
      sfr_in.sel = sel;
      @(negedge clk_in);
      sfr_in = '0;
      @(negedge clk_in);
      got = rdata_out;
   endtask

   task rd_chk(input sfr_sel_e sel, input logic [7:0] exp, input string what);
      rd_reg(sel);
      chk(got, exp, what);
   endtask

   task ctrl(input logic [7:0] d);
      wr_reg(SEL_IND, d);
   endtask

   task flags_chk(input logic done_exp, input logic mf_exp);
      chk({7'h00, write_done_flag_out}, {7'h00, done_exp}, "done flag");
      chk({7'h00, mf_request_out}, {7'h00, mf_exp}, "shared flag");
   endtask

   // slow asynchronous timer tick, long enough for the synchroniser
   task tick;
      timer_tick_in = 1'b1;
      repeat (3) @(negedge clk_in);
      timer_tick_in = 1'b0;
      repeat (3) @(negedge clk_in);
   endtask

   task do_store(input logic [7:0] a, input logic [7:0] d);
      int i;
      wr_reg(SEL_ADDR, a);
      wr_reg(SEL_DATA, d);
      ctrl(8'h08);
      ctrl(8'h0C);
      rd_chk(SEL_IND, 8'h0C, "store busy");
      flags_chk(1'b0, 1'b0);
      tick;
      rd_chk(SEL_IND, 8'h0C, "busy after one tick");
      tick;
      for (i = 0; i < 30; i++) begin
         rd_reg(SEL_IND);
         if (got[STORE_TRIG_BIT] === 1'b0) break;
      end
      chk(got, 8'h08, "store finished");
      flags_chk(1'b1, 1'b1);
      write_done_flag_clr_in = 1'b1;
      @(negedge clk_in);
      write_done_flag_clr_in = 1'b0;
      @(negedge clk_in);
      flags_chk(1'b0, 1'b1);
      mf_service_in = 1'b1;
      @(negedge clk_in);
      mf_service_in = 1'b0;
      @(negedge clk_in);
      flags_chk(1'b0, 1'b0);
   endtask

   task do_fetch(input logic [7:0] exp);
      wr_reg(SEL_DATA, 8'h00);
      ctrl(8'h02);
      ctrl(8'h03);
      rd_chk(SEL_IND, 8'h03, "fetch busy");
      repeat (8) @(negedge clk_in);
      rd_chk(SEL_IND, 8'h02, "fetch finished");
      rd_chk(SEL_DATA, exp, "fetched byte");
      rd_chk(SEL_DATA, exp, "fetched byte held");
   endtask

   initial begin
      #100000;
      error_cnt++;
      $display("MISMATCH t=%0t watchdog expired", $time);
      complete_run;
   end

   initial begin
      repeat (6) @(posedge clk_in);
      @(negedge clk_in);
      rstn_in = 1'b1;
      repeat (3) @(negedge clk_in);
      flags_chk(1'b0, 1'b0);
      rd_chk(SEL_ADDR, 8'h00, "address after reset");
      rd_chk(SEL_DATA, 8'h00, "data after reset");
      wr_reg(SEL_PTR, 8'h40);
      rd_chk(SEL_IND, 8'h00, "bank zero port");
      ctrl(8'h0A);
      wr_reg(SEL_BANK, 8'h01);
      rd_chk(SEL_IND, 8'h00, "ctrl after bank zero write");
      ctrl(8'h04);
      rd_chk(SEL_IND, 8'h00, "store trigger no permit");
      ctrl(8'h01);
      rd_chk(SEL_IND, 8'h00, "fetch trigger no permit");
      ctrl(8'h0F);
      rd_chk(SEL_IND, 8'h0A, "permit and trigger at once");
      ctrl(8'h0F);
      rd_chk(SEL_IND, 8'h0A, "both triggers");
      ctrl(8'hF8);
      rd_chk(SEL_IND, 8'h08, "upper ctrl bits");
      wr_reg(SEL_PTR, 8'h41);
      rd_chk(SEL_IND, 8'h00, "wrong pointer");
      wr_reg(SEL_PTR, 8'h40);
      wr_reg(SEL_ADDR, 8'hFF);
      rd_chk(SEL_ADDR, 8'h3F, "address padding");
      wr_reg(SEL_DATA, 8'hC3);
      rd_chk(SEL_DATA, 8'hC3, "data register");
      tick;
      do_store(8'h05, 8'hA5);
      do_fetch(8'hA5);
      ctrl(8'h06);
      rd_chk(SEL_IND, 8'h02, "store permit cleared");
      do_store(8'h3F, 8'h5A);
      do_fetch(8'h5A);
      wr_reg(SEL_ADDR, 8'h05);
      do_fetch(8'hA5);
      ctrl(8'h00);
      ctrl(8'h01);
      rd_chk(SEL_IND, 8'h00, "fetch permit cleared");
      rd_chk(SEL_DATA, 8'hA5, "data kept on refused fetch");
      complete_run;
   end
endmodule
